/* bcs_codec_end.sv */
`timescale 1ns/1ns
module bcs_codec_end #(
  parameter bit DECODER = 1'b0
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  bcs_stream_if.dev st
);
  localparam int unsigned FW = bcs_pkg::SYM_W + 2 + bcs_pkg::ERR_W;

  // ****************************************
  // Input side and framing
  // ****************************************
  bcs_pkg::bcs_state_t st_q;
  logic [bcs_pkg::CNT_W-1:0] cnt_q;
  logic [bcs_pkg::SYM_W-1:0] acc_q;
  logic [bcs_pkg::ERR_W-1:0] err_q;
  logic rdy_q;
  logic f_wr_ready;
  logic [FW-1:0] f_rd_data;
  logic f_rd_valid;

  // Ready also needs FIFO room now, since rdy_q is one cycle stale
  wire take = st.load && rdy_q && f_wr_ready;
  wire in_first = take && st.sop_in;
  wire last_msg = (cnt_q == bcs_pkg::CNT_W'(bcs_pkg::MSG_WORDS - 2));
  wire in_chk = (st_q == bcs_pkg::BCS_CHK);
  wire chk_last = (cnt_q == bcs_pkg::CNT_W'(bcs_pkg::CHK_WORDS - 1));
  // Decoder passes the word through, encoder appends check words
  wire enc_chk = !DECODER && in_chk;
  wire wr_v = enc_chk || take;
  wire [bcs_pkg::SYM_W-1:0] wr_sym = enc_chk ? acc_q : st.data_in;
  wire wr_sop = take && st.sop_in;
  wire wr_eop = enc_chk ? chk_last : (DECODER && take && st.eop_in);
  wire [bcs_pkg::ERR_W-1:0] err_nx = err_q + bcs_pkg::ERR_W'(take && st.in_erasure);
  wire [bcs_pkg::ERR_W-1:0] wr_err = wr_eop ? (DECODER ? err_nx : bcs_pkg::ERR_RST) : bcs_pkg::ERR_RST;
  wire [bcs_pkg::SYM_W-1:0] acc_nx = bcs_pkg::chk_step(in_first ? bcs_pkg::CHK_INIT : acc_q, st.data_in);
  // Ready only with FIFO room so a taken word is never dropped
  wire room = f_wr_ready;

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      st_q <= bcs_pkg::BCS_IDLE;
      cnt_q <= bcs_pkg::CNT_RST;
      acc_q <= bcs_pkg::CHK_INIT;
      err_q <= bcs_pkg::ERR_RST;
      rdy_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        bcs_pkg::BCS_IDLE:
        begin
          rdy_q <= room;
          if (take && st.sop_in)
          begin
            acc_q <= acc_nx;
            err_q <= err_nx;
            cnt_q <= bcs_pkg::CNT_RST;
            if (DECODER && st.eop_in)
            begin
              err_q <= bcs_pkg::ERR_RST;
            end
            else
            begin
              st_q <= bcs_pkg::BCS_MSG;
              rdy_q <= room && !(!DECODER && (bcs_pkg::MSG_WORDS == 2));
            end
          end
        end
        bcs_pkg::BCS_MSG:
        begin
          rdy_q <= room && !(!DECODER && last_msg && take);
          if (take)
          begin
            acc_q <= acc_nx;
            err_q <= err_nx;
            cnt_q <= cnt_q + 1'b1;
            if (DECODER && st.eop_in)
            begin
              st_q <= bcs_pkg::BCS_IDLE;
              err_q <= bcs_pkg::ERR_RST;
            end
            else if (!DECODER && (st.eop_in || cnt_q == bcs_pkg::CNT_W'(bcs_pkg::MSG_WORDS - 1)))
            begin
              st_q <= bcs_pkg::BCS_CHK;
              cnt_q <= bcs_pkg::CNT_RST;
              rdy_q <= 1'b0;
            end
          end
        end
        bcs_pkg::BCS_CHK:
        begin
          rdy_q <= 1'b0;
          if (enc_chk && f_wr_ready)
          begin
            acc_q <= bcs_pkg::chk_step(acc_q, bcs_pkg::CHK_INIT);
            cnt_q <= cnt_q + 1'b1;
            if (chk_last)
            begin
              st_q <= bcs_pkg::BCS_IDLE;
              cnt_q <= bcs_pkg::CNT_RST;
            end
          end
        end
        default:
        begin
          st_q <= bcs_pkg::BCS_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Output buffer and register stage
  // ****************************************
  logic [bcs_pkg::SYM_W-1:0] dout_q;
  logic vout_q;
  logic sop_q;
  logic eop_q;
  logic [bcs_pkg::ERR_W-1:0] ecnt_q;
  // Output stage reloads when empty or accepted downstream
  wire adv = !vout_q || st.sink_ready;
  wire pop = adv && f_rd_valid;

  bcs_fifo #(
    .WIDTH(FW),
    .DEPTH(bcs_pkg::FIFO_DEPTH),
    .AW(bcs_pkg::FIFO_AW)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .wr_data_i({wr_err, wr_sop, wr_eop, wr_sym}),
    .wr_valid_i(wr_v),
    .wr_ready_o(f_wr_ready),
    .rd_data_o(f_rd_data),
    .rd_valid_o(f_rd_valid),
    .rd_ready_i(adv)
  );

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      vout_q <= 1'b0;
      dout_q <= bcs_pkg::SYM_RST;
      sop_q <= 1'b0;
      eop_q <= 1'b0;
      ecnt_q <= bcs_pkg::ERR_RST;
    end
    else if (adv)
    begin
      vout_q <= pop;
      dout_q <= pop ? f_rd_data[bcs_pkg::SYM_W-1:0] : dout_q;
      eop_q <= pop && f_rd_data[bcs_pkg::SYM_W];
      sop_q <= pop && f_rd_data[bcs_pkg::SYM_W+1];
      ecnt_q <= pop ? f_rd_data[FW-1 -: bcs_pkg::ERR_W] : ecnt_q;
    end
  end

  assign st.ready = rdy_q && f_wr_ready;
  assign st.data_out = dout_q;
  assign st.valid_out = vout_q;
  assign st.sop_out = sop_q;
  assign st.eop_out = eop_q;
  assign st.error_count = ecnt_q;
endmodule

/* bcs_fifo.sv */
`timescale 1ns/1ns
module bcs_fifo #(
  parameter int unsigned WIDTH = 22,
  parameter int unsigned DEPTH = bcs_pkg::FIFO_DEPTH,
  parameter int unsigned AW = bcs_pkg::FIFO_AW
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  output logic [WIDTH-1:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire full = (cnt_q == (AW+1)'(DEPTH));
  wire empty = (cnt_q == '0);
  wire do_wr = wr_valid_i && !full;
  wire do_rd = rd_ready_i && !empty;

  assign wr_ready_o = !full;
  assign rd_valid_o = !empty;
  assign rd_data_o = mem_q[rp_q];

  always_ff @(posedge clk_sys_i)
  begin
    if (do_wr)
    begin
      mem_q[wp_q] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wp_q <= wp_q + 1'b1;
      end
      if (do_rd)
      begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

/* bcs_pkg.sv */
package bcs_pkg;
  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int unsigned SYM_W = 20;
  localparam int unsigned ERR_W = 8;
  localparam int unsigned MSG_WORDS = 8;
  localparam int unsigned CHK_WORDS = 3;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FIFO_AW = 4;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  localparam logic [ERR_W-1:0] ERR_RST = 8'h00;
  localparam logic [SYM_W-1:0] SYM_RST = 20'h0_0000;
  localparam logic [SYM_W-1:0] CHK_INIT = 20'h0_0000;

  typedef enum logic [1:0] {
    BCS_IDLE = 2'b00,
    BCS_MSG = 2'b01,
    BCS_CHK = 2'b10
  } bcs_state_t;

  // Check symbol step: simple rotate-xor signature, not real code arithmetic
  function automatic logic [SYM_W-1:0] chk_step(input logic [SYM_W-1:0] acc, input logic [SYM_W-1:0] sym);
    chk_step = {acc[SYM_W-2:0], acc[SYM_W-1]} ^ sym;
  endfunction
endpackage

/* bcs_stream_if.sv */
`timescale 1ns/1ns
interface bcs_stream_if;
  logic [bcs_pkg::SYM_W-1:0] data_in;
  logic load;
  logic sop_in;
  logic eop_in;
  logic in_erasure;
  logic ready;
  logic [bcs_pkg::SYM_W-1:0] data_out;
  logic valid_out;
  logic sop_out;
  logic eop_out;
  logic [bcs_pkg::ERR_W-1:0] error_count;
  logic sink_ready;

  modport dev (
    input data_in, load, sop_in, eop_in, in_erasure, sink_ready,
    output ready, data_out, valid_out, sop_out, eop_out, error_count
  );
  modport peer (
    output data_in, load, sop_in, eop_in, in_erasure, sink_ready,
    input ready, data_out, valid_out, sop_out, eop_out, error_count
  );
endinterface

/* bcs_stream_sva.sv */
`timescale 1ns/1ns
module bcs_stream_sva (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic load,
  input wire logic ready,
  input wire logic eop_in,
  input wire logic [bcs_pkg::SYM_W-1:0] data_out,
  input wire logic valid_out,
  input wire logic sop_out,
  input wire logic eop_out,
  input wire logic sink_ready
);
  // ********
  // Output frame tracker
  // ********
  logic xfer;
  logic in_cw_q;
  logic in_cw_d;
  logic [3:0] n_out_q;
  logic [3:0] n_out_d;
  assign xfer = valid_out && sink_ready;
  assign in_cw_d = xfer ? !eop_out : in_cw_q;
  assign n_out_d = !xfer ? n_out_q : (eop_out ? 4'h0 : n_out_q + 4'h1);
  always_ff @(posedge clk_sys_i)
  begin
    in_cw_q <= srst_i ? 1'b0 : in_cw_d;
    n_out_q <= srst_i ? 4'h0 : n_out_d;
  end
  // ********
  // Properties
  // ********
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  property p_rst;
    $fell(srst_i) |-> !ready && !valid_out && !sop_out && !eop_out;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  property p_idle;
    $fell(srst_i) |-> !valid_out [*2];
  endproperty
  a_idle: assert property (p_idle) else $error("valid without data");
  property p_hold;
    valid_out && !sink_ready |=> valid_out && $stable(data_out) && $stable(sop_out) && $stable(eop_out);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved while stalled");
  property p_flagv;
    sop_out || eop_out |-> valid_out;
  endproperty
  a_flagv: assert property (p_flagv) else $error("framing without valid");
  property p_first;
    xfer && !in_cw_q |-> sop_out;
  endproperty
  a_first: assert property (p_first) else $error("first word lacks start");
  property p_once;
    xfer && in_cw_q |-> !sop_out;
  endproperty
  a_once: assert property (p_once) else $error("start flag repeated");
  property p_last;
    xfer |-> eop_out == (n_out_q == 4'ha);
  endproperty
  a_last: assert property (p_last) else $error("end flag misplaced");
  property p_rdy;
    load && ready && eop_in |=> !ready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready kept in check phase");
endmodule

/* bcs_user_end.sv */
`timescale 1ns/1ns
module bcs_user_end (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  bcs_stream_if.peer st,
  input wire logic [bcs_pkg::SYM_W-1:0] usr_data_i,
  input wire logic usr_valid_i,
  input wire logic usr_sop_i,
  input wire logic usr_eop_i,
  input wire logic usr_erasure_i,
  output logic usr_ready_o,
  input wire logic usr_sink_ready_i,
  output logic [bcs_pkg::SYM_W-1:0] usr_data_o,
  output logic usr_valid_o,
  output logic usr_sop_o,
  output logic usr_eop_o,
  output logic [bcs_pkg::ERR_W-1:0] usr_err_o
);
  // ****************************************
  // Source: hold word until taken
  // ****************************************
  logic hv_q;
  logic [bcs_pkg::SYM_W-1:0] hd_q;
  logic hs_q;
  logic he_q;
  logic hx_q;
  logic infr_q;
  wire sent = hv_q && st.ready;
  wire ok = usr_valid_i && (infr_q ? !usr_sop_i : usr_sop_i);
  // Ready means the next edge takes the word; half rate, no skid buffer
  wire usr_take = usr_ready_o && ok;
  wire hv_d = usr_take || (hv_q && !sent);

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      hv_q <= 1'b0;
      hd_q <= bcs_pkg::SYM_RST;
      hs_q <= 1'b0;
      he_q <= 1'b0;
      hx_q <= 1'b0;
      infr_q <= 1'b0;
      usr_ready_o <= 1'b0;
    end
    else
    begin
      hv_q <= hv_d;
      usr_ready_o <= !hv_d;
      if (usr_take)
      begin
        hd_q <= usr_data_i;
        hs_q <= usr_sop_i;
        he_q <= usr_eop_i;
        hx_q <= usr_erasure_i;
        infr_q <= !usr_eop_i;
      end
    end
  end

  assign st.load = hv_q;
  assign st.data_in = hd_q;
  assign st.sop_in = hs_q;
  assign st.eop_in = he_q;
  assign st.in_erasure = hx_q;

  // ****************************************
  // Sink: register outputs
  // ****************************************
  logic srdy_q;
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      srdy_q <= 1'b0;
      usr_valid_o <= 1'b0;
      usr_data_o <= bcs_pkg::SYM_RST;
      usr_sop_o <= 1'b0;
      usr_eop_o <= 1'b0;
      usr_err_o <= bcs_pkg::ERR_RST;
    end
    else
    begin
      srdy_q <= usr_sink_ready_i;
      usr_valid_o <= st.valid_out && srdy_q;
      usr_data_o <= st.data_out;
      usr_sop_o <= st.valid_out && srdy_q && st.sop_out;
      usr_eop_o <= st.valid_out && srdy_q && st.eop_out;
      usr_err_o <= st.error_count;
    end
  end
  assign st.sink_ready = srdy_q;
endmodule

/* tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  // ********
  // Stimulus and monitors
  // ********
  localparam int N = bcs_pkg::MSG_WORDS + bcs_pkg::CHK_WORDS;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic [bcs_pkg::SYM_W-1:0] usr_data_i = 20'h0_0000;
  logic usr_valid_i = 1'b0;
  logic usr_sop_i = 1'b0;
  logic usr_eop_i = 1'b0;
  logic usr_erasure_i = 1'b0;
  logic usr_sink_ready_i = 1'b1;
  logic usr_ready_o;
  logic [bcs_pkg::SYM_W-1:0] usr_data_o;
  logic usr_valid_o;
  logic usr_sop_o;
  logic usr_eop_o;
  logic [bcs_pkg::ERR_W-1:0] usr_err_o;
  logic [21:0] got_q[$];
  logic refused = 1'b0;
  int stall_n = 0;
  int miscompares = 0;
  int n_checks = 0;
  initial forever #25 clk_sys_i = ~clk_sys_i;
  bcs_stream_if i_bcs_stream_if ();
  bcs_codec_end #(.DECODER(1'b0)) i_bcs_codec_end (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .st(i_bcs_stream_if));
  bcs_user_end i_bcs_user_end (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .st(i_bcs_stream_if),
    .usr_data_i(usr_data_i), .usr_valid_i(usr_valid_i), .usr_sop_i(usr_sop_i), .usr_eop_i(usr_eop_i),
    .usr_erasure_i(usr_erasure_i), .usr_ready_o(usr_ready_o), .usr_sink_ready_i(usr_sink_ready_i),
    .usr_data_o(usr_data_o), .usr_valid_o(usr_valid_o), .usr_sop_o(usr_sop_o), .usr_eop_o(usr_eop_o),
    .usr_err_o(usr_err_o));
  bcs_stream_sva i_bcs_stream_sva (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .load(i_bcs_stream_if.load),
    .ready(i_bcs_stream_if.ready), .eop_in(i_bcs_stream_if.eop_in), .data_out(i_bcs_stream_if.data_out),
    .valid_out(i_bcs_stream_if.valid_out), .sop_out(i_bcs_stream_if.sop_out),
    .eop_out(i_bcs_stream_if.eop_out), .sink_ready(i_bcs_stream_if.sink_ready));
  always @(posedge clk_sys_i)
  begin
    // Registered copy already marks a transfer; pin ready is a cycle ahead
    if (usr_valid_o === 1'b1)
      got_q.push_back({usr_sop_o, usr_eop_o, usr_data_o});
    // Long refusal only, short gaps are the normal half-rate handshake
    stall_n = (usr_valid_i === 1'b1 && usr_ready_o === 1'b0) ? stall_n + 1 : 0;
    if (stall_n > 12)
      refused = 1'b1;
  end
  // ********
  // Tasks
  // ********
  task automatic chk(input string what, input logic [21:0] exp, input logic [21:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic send_cw(input logic [19:0] base);
    int t;
    for (int i = 0; i < bcs_pkg::MSG_WORDS; i++)
    begin
      usr_valid_i <= 1'b1;
      usr_sop_i <= (i == 0);
      usr_eop_i <= (i == bcs_pkg::MSG_WORDS - 1);
      usr_data_i <= base + i[19:0];
      t = 0;
      @(posedge clk_sys_i);
      // Word held until taken, never dropped
      while (usr_ready_o !== 1'b1 && t < 400)
      begin
        @(posedge clk_sys_i);
        t++;
      end
      if (t >= 400)
      begin
        miscompares++;
        print_verdict();
      end
    end
    // Junk on the bus while not valid, must be ignored
    usr_valid_i <= 1'b0;
    usr_sop_i <= 1'b1;
    usr_data_i <= ~base;
    @(posedge clk_sys_i);
  endtask
  task automatic expect_cw(input logic [19:0] base);
    int t;
    logic [21:0] w;
    t = 0;
    while (got_q.size() < N && t < 2000)
    begin
      @(posedge clk_sys_i);
      t++;
    end
    if (got_q.size() < N)
    begin
      miscompares++;
      print_verdict();
    end
    for (int i = 0; i < N; i++)
    begin
      w = got_q.pop_front();
      chk("framing", {i == 0, i == N - 1, 20'h0_0000}, {w[21:20], 20'h0_0000});
      if (i < bcs_pkg::MSG_WORDS)
        chk("data_out", {2'b00, base + i[19:0]}, {2'b00, w[19:0]});
    end
  endtask
  // ********
  // Main sequence
  // ********
  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    send_cw(20'h0_0100);
    expect_cw(20'h0_0100);
    $display("test plain codeword done");
    // Stalled sink: buffer fills and input is refused
    usr_sink_ready_i <= 1'b0;
    fork
      begin
        send_cw(20'h0_0200);
        send_cw(20'h0_0300);
      end
      begin
        repeat (80) @(posedge clk_sys_i);
        usr_sink_ready_i <= 1'b1;
      end
    join
    chk("refused", 22'h00_0001, {21'h00_0000, refused});
    expect_cw(20'h0_0200);
    expect_cw(20'h0_0300);
    $display("test backpressure done");
    usr_sink_ready_i <= 1'b0;
    send_cw(20'h0_0400);
    srst_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    chk("reset outputs", 22'h00_0000, {20'h0_0000, usr_valid_o, usr_ready_o});
    srst_i <= 1'b0;
    got_q.delete();
    usr_sink_ready_i <= 1'b1;
    // Whole codeword after a reset in mid-frame
    send_cw(20'h0_0500);
    expect_cw(20'h0_0500);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
